// ===== hdl/dacc_pkg.sv
// Package with register map, field positions and timing for the DAC control.
package dacc_pkg;
  // ==========================================================================
  // Register map (byte addresses are four times the printed index)
  // ==========================================================================
  localparam logic [3:0] ctrl_index = 4'h0;
  localparam logic [3:0] data_index = 4'h1;
  localparam logic [3:0] status_index = 4'h2;
  localparam int addr_width = 4;
  // ==========================================================================
  // Control fields
  // ==========================================================================
  localparam int ctrl_enable_bit = 0;
  localparam int ctrl_pin_driver_enable_bit = 6;
  localparam int ctrl_standby_keep_running_bit = 7;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [7:0] ctrl_mask = 8'hc1;
  localparam logic [7:0] data_reset = 8'h00;
  // ==========================================================================
  // Status fields
  // ==========================================================================
  localparam int status_active_bit = 0;
  localparam int status_busy_bit = 1;
  localparam int status_pin_bit = 2;
  // ==========================================================================
  // Timing: one conversion slot at the top rate of 350 ksps
  // ==========================================================================
  localparam int clock_mhz = 125;
  localparam int sample_rate_ksps = 350;
  localparam int conv_cycles = (clock_mhz * 1000) / sample_rate_ksps;
  localparam int conv_width = 9;
endpackage : dacc_pkg

// ===== hdl/dacc_top.sv
// DAC control logic: registers, conversion start and output gating.
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ps

// Functional notes
// - Software writes 8-bit code driven to converter.
// - Each data register write while running starts a conversion.
// - Conversions keep pace with 350 ksps writes.
// - Converter scales code from ground to reference.
// - Logic runs from peripheral clock only.
// - Converted output feeds comparator and ADC.
// - Disabled write stores; enabling starts conversion.
// - Pin driven only with pin driver enable.
// - Standby stops converter unless keep-running set.
module dacc_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic standby,
  output logic [7:0] conv_code,
  output logic conv_start,
  output logic conv_active,
  output logic pin_driver_on,
  output logic internal_out_valid
);
  // ==========================================================================
  // Bus decode
  // ==========================================================================
  logic [7:0] ctrl;
  logic [7:0] data;
  logic busy;
  logic [8:0] conv_count;
  logic acked;
  logic [7:0] status;
  wire word_ok = address[1:0] == 2'b00;
  wire [3:0] index = address[5:2];
  wire access = (read | write) & clock_enable & ~acked;
  wire wr_ctrl = access & write & word_ok & (index == dacc_pkg::ctrl_index);
  wire wr_data = access & write & word_ok & (index == dacc_pkg::data_index);
  wire enable = ctrl[dacc_pkg::ctrl_enable_bit];
  wire keep_run = ctrl[dacc_pkg::ctrl_standby_keep_running_bit];
  wire out_en = ctrl[dacc_pkg::ctrl_pin_driver_enable_bit];
  wire running = enable & (~standby | keep_run);
  wire next_enable = wr_ctrl ? writedata[dacc_pkg::ctrl_enable_bit] : enable;
  wire next_keep =
    wr_ctrl ? writedata[dacc_pkg::ctrl_standby_keep_running_bit] : keep_run;
  wire next_running = next_enable & (~standby | next_keep);
  wire start_on_write = wr_data & next_running;
  // start on enable
  // Comparing against the registered state as well makes a wake from
  // standby restart the converter, which needs a fresh start-up.
  wire start_on_enable = next_running & ~(running & conv_active);
  wire next_start = start_on_write | start_on_enable;
  // Status bits sit where the package places them.
  always_comb begin
    status = 8'h00;
    status[dacc_pkg::status_active_bit] = running;
    status[dacc_pkg::status_busy_bit] = busy;
    status[dacc_pkg::status_pin_bit] = out_en & running;
  end
  wire [31:0] next_readdata =
    ~word_ok ? 32'h0000_0000 :
    (index == dacc_pkg::ctrl_index) ? {24'h000000, ctrl} :
    (index == dacc_pkg::data_index) ? {24'h000000, data} :
    (index == dacc_pkg::status_index) ? {24'h000000, status} :
    32'h0000_0000;

  // ==========================================================================
  // Registers and bus answer
  // ==========================================================================
  // Every access answers in the cycle after it is seen; acked drops the
  // request for one cycle so a held request is never taken twice.
  // The waitrequest output is a flop of its own, the inverse of acked, so
  // the bus never sees decode glitches on it.
  // single clock
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl <= dacc_pkg::ctrl_reset;
      data <= dacc_pkg::data_reset;
      acked <= 1'b0;
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else if (clock_enable) begin
      acked <= access;
      waitrequest <= ~access;
      if (access && read) begin
        readdata <= next_readdata;
      end
      if (wr_ctrl) begin
        ctrl <= writedata[7:0] & dacc_pkg::ctrl_mask;
      end
      if (wr_data) begin
        data <= writedata[7:0];
      end
    end
  end

  // ==========================================================================
  // Conversion control
  // ==========================================================================
  // The busy window is one 350 ksps slot; a new write restarts it rather
  // than being refused, so writes at full rate each give a new output.
  always_ff @(posedge clock) begin
    if (rst) begin
      conv_code <= dacc_pkg::data_reset;
      conv_start <= 1'b0;
      conv_active <= 1'b0;
      pin_driver_on <= 1'b0;
      internal_out_valid <= 1'b0;
      busy <= 1'b0;
      conv_count <= 9'h000;
    end else if (clock_enable) begin
      conv_start <= next_start;
      conv_active <= next_running;
      pin_driver_on <= next_running & (wr_ctrl ?
        writedata[dacc_pkg::ctrl_pin_driver_enable_bit] : out_en);
      internal_out_valid <= next_running;
      if (wr_data) begin
        conv_code <= writedata[7:0];
      end
      if (next_start) begin
        busy <= 1'b1;
        conv_count <= 9'(dacc_pkg::conv_cycles - 1);
      end else if (conv_count != 9'h000) begin
        conv_count <= conv_count - 9'h001;
      end else begin
        busy <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_write_starts: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && wr_data && next_running) |=> conv_start)
    else $error("data write while running gave no start");
  a_disabled_store: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && wr_data && !next_running && running == next_running)
    |=> !conv_start)
    else $error("disabled data write started a conversion");
  a_enable_starts: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && !running && next_running) |=> conv_start && conv_active)
    else $error("enable did not start a conversion");
  a_code_follows: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && wr_data) |=> conv_code == $past(writedata[7:0]))
    else $error("code not presented after write");
  a_code_holds: assert property (@(posedge clock) disable iff (rst)
    !wr_data |=> $stable(conv_code))
    else $error("code changed without a write");
  a_pin_gated: assert property (@(posedge clock) disable iff (rst)
    pin_driver_on |-> conv_active && out_en)
    else $error("pin driven without enable");
  a_standby_stop: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && standby && !keep_run && !wr_ctrl) |=> !conv_active)
    else $error("converter ran in standby");
  a_internal_feed: assert property (@(posedge clock) disable iff (rst)
    internal_out_valid == conv_active)
    else $error("internal feed differs from enable");
  a_slot_length: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && next_start) |=>
    conv_count == 9'(dacc_pkg::conv_cycles - 1))
    else $error("conversion slot length wrong");
  a_bus_answer: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && access) |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle");

  // ==========================================================================
  // Register, freeze and slot checks
  // ==========================================================================
  // These watch the registers, the bus answer and the converter outputs, where a slip shows only as a wrong level.
  a_wait_idle: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && !access) |=> waitrequest)
    else $error("waitrequest low without an access");
  a_write_lands: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && wr_data) |=> data == $past(writedata[7:0]))
    else $error("data register missed a write");
  a_refused_write: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && access && write && !wr_ctrl && !wr_data)
    |=> $stable(ctrl) && $stable(data))
    else $error("unmapped write changed a register");
  a_ctrl_write: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && wr_ctrl)
    |=> ctrl == ($past(writedata[7:0]) & dacc_pkg::ctrl_mask))
    else $error("control register missed a write");
  a_read_data: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && access && read && !write && word_ok &&
    index == dacc_pkg::data_index) |=> readdata == {24'h000000, data})
    else $error("data read back wrong");
  a_status_read: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && access && read && word_ok &&
    index == dacc_pkg::status_index)
    |=> readdata[dacc_pkg::status_pin_bit] ==
    ($past(out_en) & $past(running)))
    else $error("status pin bit wrong");
  a_freeze_holds: assert property (@(posedge clock) disable iff (rst)
    !clock_enable |=> $stable(conv_code) && $stable(conv_active) &&
    $stable(conv_start) && $stable(waitrequest) && $stable(readdata))
    else $error("state moved while clock enable was low");
  a_disabled_quiet: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && !next_enable)
    |=> !conv_active && !conv_start && !pin_driver_on)
    else $error("disabled converter still active");
  a_pin_follows: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && next_running && !wr_ctrl && out_en) |=> pin_driver_on)
    else $error("pin not driven while enabled");
  a_keep_running: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && next_enable && next_keep) |=> conv_active)
    else $error("keep-running converter stopped");
  a_wake_starts: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && next_running && !conv_active) |=> conv_start)
    else $error("no start on wake or enable");
  a_busy_set: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && next_start) |=> busy)
    else $error("busy not set by a start");
  a_busy_ends: assert property (@(posedge clock) disable iff (rst)
    (clock_enable && !next_start && conv_count == 9'h000) |=> !busy)
    else $error("busy outlived its slot");
endmodule : dacc_top

// ===== verification/dacc_top_tb_top.sv
// Self-checking random testbench for the DAC control block.
`timescale 1ns/1ps
module dacc_top_tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic clock_enable = 1'b1;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic standby = 1'b0;
  logic [31:0] readdata, rd;
  logic waitrequest, conv_start, conv_active, pin_driver_on, st;
  logic internal_out_valid;
  logic [7:0] conv_code;
  logic [31:0] seed = 32'hdb75484e;
  int error_cnt = 0;
  int n_checks = 0;
  always #4 clock = ~clock;
  dacc_top i_dacc_top (.clock(clock), .rst(rst), .address(address),
    .clock_enable(clock_enable), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .standby(standby),
    .waitrequest(waitrequest), .conv_code(conv_code),
    .conv_start(conv_start), .conv_active(conv_active),
    .pin_driver_on(pin_driver_on), .internal_out_valid(internal_out_valid));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [31:0] ctrl_view(input logic [7:0] v);
    return {24'h0, v & dacc_pkg::ctrl_mask};
  endfunction : ctrl_view
  function automatic logic [31:0] status_view(input logic a, input logic b,
    input logic p);
    logic [31:0] v;
    v = 32'h0;
    v[dacc_pkg::status_active_bit] = a;
    v[dacc_pkg::status_busy_bit] = b;
    v[dacc_pkg::status_pin_bit] = p;
    return v;
  endfunction : status_view
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // The request is held until waitrequest is seen low; the bound stops hangs.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= {seed[31:8], d};
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    st = conv_start;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) chk(32'h1, 32'h0);
  endtask : bus
  task automatic final_report();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, 6'h04, 8'h00);
    chk(rd, 32'h0);
    bus(1'b1, 6'h04, 8'h5a);
    chk(st, 1'b0);
    bus(1'b0, 6'h04, 8'h00);
    chk(rd, 32'h5a);
    bus(1'b1, 6'h00, 8'h01);
    chk(st, 1'b1);
    chk(conv_code, 8'h5a);
    repeat (3) @(posedge clock);
    chk({conv_active, internal_out_valid, pin_driver_on}, 3'b110);
    // Back-to-back writes at full bus rate must each start a conversion.
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      bus(1'b1, 6'h04, seed[7:0]);
      chk(st, 1'b1);
      chk(conv_code, {24'h0, seed[7:0]});
    end
    repeat (10) @(posedge clock);
    chk(conv_code, {24'h0, seed[7:0]});
    bus(1'b1, 6'h00, 8'h41);
    repeat (3) @(posedge clock);
    chk(pin_driver_on, 1'b1);
    bus(1'b0, 6'h08, 8'h00);
    chk(rd, status_view(1'b1, 1'b1, 1'b1));
    // With the clock enable low, standby must not reach the outputs.
    clock_enable <= 1'b0;
    standby <= 1'b1;
    repeat (3) @(posedge clock);
    chk({conv_active, pin_driver_on}, 2'b11);
    clock_enable <= 1'b1;
    standby <= 1'b1;
    repeat (3) @(posedge clock);
    chk({conv_active, pin_driver_on}, 2'b00);
    standby <= 1'b0;
    repeat (2) @(posedge clock);
    chk(conv_start, 1'b1);
    repeat (3) @(posedge clock);
    chk({conv_active, pin_driver_on}, 2'b11);
    bus(1'b1, 6'h00, 8'hc1);
    standby <= 1'b1;
    repeat (3) @(posedge clock);
    chk({conv_active, pin_driver_on}, 2'b11);
    standby <= 1'b0;
    bus(1'b1, 6'h00, 8'h00);
    repeat (3) @(posedge clock);
    chk({conv_active, internal_out_valid, pin_driver_on}, 3'b000);
    repeat (360) @(posedge clock);
    bus(1'b0, 6'h08, 8'h00);
    chk(rd, status_view(1'b0, 1'b0, 1'b0));
    bus(1'b1, 6'h0c, 8'hff);
    bus(1'b0, 6'h0c, 8'h00);
    chk(rd, 32'h0);
    bus(1'b1, 6'h00, 8'hfe);
    bus(1'b0, 6'h00, 8'h00);
    chk(rd, ctrl_view(8'hfe));
    // A reset in mid-run must clear the held code and the bus answer.
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk({conv_code, waitrequest}, 9'h001);
    bus(1'b0, 6'h04, 8'h00);
    chk(rd, 32'h0);
    final_report();
  end
  // A run that outlasts 20000 cycles ends through the same closing task as a failure.
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    final_report();
  end
endmodule : dacc_top_tb_top
